// ---- ewsp_consts.vh ----
`ifndef EWSP_CONSTS_VH
`define EWSP_CONSTS_VH

// register indices on the plain register port
`define EWSP_REG_READ_PAGE    4'h0
`define EWSP_REG_WRITE_PAGE   4'h1
`define EWSP_REG_STATUS       4'h2
`define EWSP_REG_CLEAR        4'h3
`define EWSP_REG_ENABLE       4'h4
`define EWSP_REG_CONFIG       4'h5
`define EWSP_REG_LAST_EA_LO   4'h6
`define EWSP_REG_LAST_EA_HI   4'h7

// reset values
`define EWSP_READ_PAGE_RST    10'h001
`define EWSP_WRITE_PAGE_RST   9'h001
`define EWSP_CONFIG_RST       1'b1

// address field layout
`define EWSP_WINDOW_BIT       15
`define EWSP_PAGE_W           9
`define EWSP_OFFSET_W         15
`define EWSP_PSV_BIT          9

// status bit positions and width
`define EWSP_ST_TRAP          0
`define EWSP_ST_RD_DONE       1
`define EWSP_ST_WR_DONE       2
`define EWSP_ST_W             3

// timing counts in instruction cycles; the slow count is in repeated reads
`define EWSP_RD_CYCLES        2'd2
`define EWSP_RPT_FIRST_CYCLES 2'd3
`define EWSP_RPT_NEXT_CYCLES  2'd1
`define EWSP_RPT_SLOW_COUNT   2'd2

// external reach: 16 MB for large port, 64 KB otherwise
`define EWSP_SMALL_PORT_MASK  24'h00ffff

`endif

// ---- ewsp_page_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ewsp_consts.vh"

module ewsp_page_regs
(
    // clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_n_in,
    // write side
    input  wire        wr_en_in,
    input  wire [3:0]  wr_addr_in,
    input  wire [15:0] wr_data_in,
    // page outputs, straight from flops
    output reg  [9:0]  read_page_out,
    output reg  [8:0]  write_page_out,
    output reg         large_port_out
);

    // page holders; only software changes them, never pointer rollover
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            read_page_out  <= `EWSP_READ_PAGE_RST;
            write_page_out <= `EWSP_WRITE_PAGE_RST;
            large_port_out <= `EWSP_CONFIG_RST;
        end
        else if (wr_en_in)
        begin
            if (wr_addr_in == `EWSP_REG_READ_PAGE)
                read_page_out <= wr_data_in[9:0];
            if (wr_addr_in == `EWSP_REG_WRITE_PAGE)
                write_page_out <= wr_data_in[8:0];
            if (wr_addr_in == `EWSP_REG_CONFIG)
                large_port_out <= wr_data_in[0];
        end
    end

endmodule
`default_nettype wire

// ---- ewsp_window_addr.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ewsp_consts.vh"

module ewsp_window_addr
(
    // clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_n_in,
    // register port
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // core access request
    input  wire        core_req_in,
    input  wire        core_write_in,
    input  wire        core_indirect_in,
    input  wire        core_repeat_in,
    input  wire        core_dword_in,
    input  wire [15:0] core_addr_in,
    output wire        core_ready_out,
    // memory side
    output reg         mem_valid_out,
    output reg         mem_write_out,
    output reg         mem_external_out,
    output reg         mem_program_view_out,
    output reg  [23:0] mem_addr_out,
    // trap and interrupt
    output reg         addr_trap_out,
    output wire        irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    wire [9:0]  read_page_select;
    wire [8:0]  write_page_select;
    wire        large_port;
    reg  [1:0]  wait_cnt;
    reg  [1:0]  rpt_cnt;
    reg         dword_second;
    reg  [15:0] held_addr;
    reg         held_write;
    reg  [`EWSP_ST_W-1:0] status;
    reg  [`EWSP_ST_W-1:0] irq_enable;
    reg  [23:0] last_ea;
    reg  [23:0] next_ea;
    reg         next_trap;
    reg         next_program_view;
    reg  [1:0]  next_cycles;
    wire        window_hit;
    wire        busy;
    wire        start;
    wire        finish;

    ////////////////////////////////////////////////////////////////////////
    // page registers in their own module

    ewsp_page_regs u_pages
    (
        .ref_clk_in     (ref_clk_in),
        .rst_n_in       (rst_n_in),
        .wr_en_in       (reg_wr_in),
        .wr_addr_in     (reg_addr_in),
        .wr_data_in     (reg_wdata_in),
        .read_page_out  (read_page_select),
        .write_page_out (write_page_select),
        .large_port_out (large_port)
    );

    ////////////////////////////////////////////////////////////////////////
    // address forming, shared by reads and writes

    // page above 15-bit offset; one page spans the 32 kilobyte window
    function [23:0] ewsp_join;
        input [8:0]  page;
        input [15:0] addr;
        begin
            ewsp_join = {page, addr[`EWSP_OFFSET_W-1:0]};
        end
    endfunction

    // window only for indirect pointers with bit 15 set
    assign window_hit = core_indirect_in & core_addr_in[`EWSP_WINDOW_BIT];

    // effective address, trap and program view decode for a new request
    always @*
    begin
        next_ea           = {8'h00, core_addr_in};
        next_trap         = 1'b0;
        next_program_view = 1'b0;
        if (window_hit)
        begin
            if (core_write_in)
            begin
                next_ea   = ewsp_join(write_page_select, core_addr_in);
                next_trap = (write_page_select == 9'h000);
            end
            else
            begin
                // read page bit 9 switches reads over to program view
                next_program_view = read_page_select[`EWSP_PSV_BIT];
                next_ea   = ewsp_join(read_page_select[8:0], core_addr_in);
                next_trap = (read_page_select == 10'h000);
            end
            if (!large_port)
                next_ea = next_ea & `EWSP_SMALL_PORT_MASK;
        end
    end

    // cycles a read costs; writes always one
    always @*
    begin
        next_cycles = `EWSP_RPT_NEXT_CYCLES;
        if (window_hit && !core_write_in)
        begin
            if (core_repeat_in)
                next_cycles = (rpt_cnt < `EWSP_RPT_SLOW_COUNT) ?
                              `EWSP_RPT_FIRST_CYCLES : `EWSP_RPT_NEXT_CYCLES;
            else
                next_cycles = `EWSP_RD_CYCLES;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencing

    assign busy           = (wait_cnt != 2'd0) | dword_second;
    assign start          = core_req_in & ~busy;
    assign finish         = (wait_cnt == 2'd1) | (start & (next_cycles == 2'd1));
    assign core_ready_out = ~busy;

    // wait counter models read overhead; second word of a double follows
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_cnt     <= 2'd0;
            rpt_cnt      <= 2'd0;
            dword_second <= 1'b0;
            held_addr    <= 16'h0000;
            held_write   <= 1'b0;
        end
        else if (start)
        begin
            wait_cnt     <= next_cycles - 2'd1;
            dword_second <= core_dword_in;
            held_addr    <= core_addr_in + 16'h0002;
            held_write   <= core_write_in;
            if (core_repeat_in && window_hit && !core_write_in)
            begin
                if (rpt_cnt != 2'd3)
                    rpt_cnt <= rpt_cnt + 2'd1;
            end
            else
                rpt_cnt <= 2'd0;
        end
        else if (wait_cnt != 2'd0)
            wait_cnt <= wait_cnt - 2'd1;
        else if (dword_second)
            dword_second <= 1'b0;
    end

    // memory port; pointer +2 wraps inside offset, page untouched
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_valid_out        <= 1'b0;
            mem_write_out        <= 1'b0;
            mem_external_out     <= 1'b0;
            mem_program_view_out <= 1'b0;
            mem_addr_out         <= 24'h000000;
            addr_trap_out        <= 1'b0;
            last_ea              <= 24'h000000;
        end
        else
        begin
            mem_valid_out <= 1'b0;
            addr_trap_out <= 1'b0;
            if (start)
            begin
                mem_valid_out        <= ~next_trap;
                mem_write_out        <= core_write_in;
                mem_external_out     <= window_hit;
                mem_program_view_out <= next_program_view;
                mem_addr_out         <= next_ea;
                addr_trap_out        <= next_trap;
                last_ea              <= next_ea;
            end
            else if (dword_second && wait_cnt == 2'd0)
            begin
                // second word keeps the same page: no rollover update
                mem_valid_out <= 1'b1;
                mem_addr_out  <= {mem_addr_out[23:15],
                                  held_addr[`EWSP_OFFSET_W-1:0]};
                mem_write_out <= held_write;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, enable and clear; set beats clear

    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status     <= {`EWSP_ST_W{1'b0}};
            irq_enable <= {`EWSP_ST_W{1'b0}};
        end
        else
        begin
            if (reg_wr_in && reg_addr_in == `EWSP_REG_ENABLE)
                irq_enable <= reg_wdata_in[`EWSP_ST_W-1:0];
            status <= (status & ~((reg_wr_in && reg_addr_in == `EWSP_REG_CLEAR) ?
                                  reg_wdata_in[`EWSP_ST_W-1:0] : {`EWSP_ST_W{1'b0}}))
                      | {start & window_hit & core_write_in,
                         finish & ~held_write & ~start | start & ~core_write_in & finish,
                         start & next_trap};
        end
    end

    assign irq_out = |(status & irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // register read, data one cycle after strobe

    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `EWSP_REG_READ_PAGE:  reg_rdata_out <= {6'h00, read_page_select};
                `EWSP_REG_WRITE_PAGE: reg_rdata_out <= {7'h00, write_page_select};
                `EWSP_REG_STATUS:     reg_rdata_out <= {13'h0000, status};
                `EWSP_REG_ENABLE:     reg_rdata_out <= {13'h0000, irq_enable};
                `EWSP_REG_CONFIG:     reg_rdata_out <= {15'h0000, large_port};
                `EWSP_REG_LAST_EA_LO: reg_rdata_out <= last_ea[15:0];
                `EWSP_REG_LAST_EA_HI: reg_rdata_out <= {8'h00, last_ea[23:16]};
                default:              reg_rdata_out <= 16'h0000;
            endcase
        end
        else
            reg_rdata_out <= 16'h0000;
    end

endmodule
`default_nettype wire

// ---- ewsp_checker_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ewsp_checker
(
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    // core side
    input wire logic        core_req_in,
    input wire logic        core_write_in,
    input wire logic        core_indirect_in,
    input wire logic        core_repeat_in,
    input wire logic        core_dword_in,
    input wire logic [15:0] core_addr_in,
    input wire logic        core_ready_out,
    // memory side
    input wire logic        mem_valid_out,
    input wire logic        mem_write_out,
    input wire logic        mem_external_out,
    input wire logic [23:0] mem_addr_out,
    input wire logic        addr_trap_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic take;
    wire logic win_take;
    // accepted request, and one aimed at the window
    assign take = core_req_in && core_ready_out;
    // only indirect pointers open the window
    assign win_take = take && core_indirect_in && core_addr_in[15];
    sequence s_win_rd;
        win_take && !core_write_in && !core_repeat_in && !core_dword_in;
    endsequence
    sequence s_wait_one;
        !core_ready_out ##1 core_ready_out;
    endsequence
    AST_RD_BUSY: assert property (s_win_rd |=> s_wait_one or addr_trap_out)
        else $error("window read not two cycles");
    AST_WIN_ADDR: assert property (win_take |=> addr_trap_out ||
        mem_addr_out[14:0] == $past(core_addr_in[14:0]))
        else $error("window offset not carried");
    AST_LOW_ADDR: assert property (take && !core_addr_in[15] |=> mem_valid_out &&
        !mem_external_out && mem_addr_out == {8'h00, $past(core_addr_in)})
        else $error("low address not passed straight");
    AST_WR_ONE: assert property (take && core_write_in && !core_dword_in |=> core_ready_out)
        else $error("write not single cycle");
    AST_WR_DIR: assert property (take && core_write_in |=> mem_write_out || addr_trap_out)
        else $error("write direction lost");
    AST_TRAP_ONE: assert property (addr_trap_out |-> !mem_valid_out ##1 !addr_trap_out)
        else $error("trap not a clean pulse");
    AST_TRAP_SRC: assert property (addr_trap_out |-> $past(win_take))
        else $error("trap without window access");
    AST_DW_STEP: assert property (take && core_dword_in && core_write_in |=> addr_trap_out or
        (mem_valid_out ##1 mem_valid_out && mem_addr_out == $past(mem_addr_out) + 24'h2))
        else $error("second word not at next address");
    AST_EXT: assert property (win_take |=> mem_external_out)
        else $error("window access not sent outward");
endmodule
bind ewsp_window_addr ewsp_checker chk_u (.ref_clk_in, .rst_n_in, .core_req_in, .core_write_in,
    .core_indirect_in,
    .core_repeat_in, .core_dword_in, .core_addr_in, .core_ready_out, .mem_valid_out,
    .mem_write_out, .mem_external_out, .mem_addr_out, .addr_trap_out);
`default_nettype wire

// ---- ewsp_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ewsp_mem_model
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // transfer side
    input  wire logic        mem_valid_in,
    input  wire logic [23:0] mem_addr_in,
    // observation
    output var  logic [23:0] last_addr_out,
    output var  logic [7:0]  beats_out
);
    // passive sink: the port carries no data, so only beats are logged
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            last_addr_out <= 24'h000000;
            beats_out     <= 8'h00;
        end
        else if (mem_valid_in)
        begin
            last_addr_out <= mem_addr_in;
            beats_out     <= beats_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic core_req_in = 1'b0, core_write_in = 1'b0, core_indirect_in = 1'b0;
    logic core_repeat_in = 1'b0, core_dword_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000, core_addr_in = 16'h0000, reg_rdata_out;
    logic core_ready_out, mem_valid_out, mem_write_out, mem_external_out;
    logic mem_program_view_out, addr_trap_out, irq_out;
    logic [23:0] mem_addr_out, last_addr, b;
    logic [7:0] beats;
    int bad_count = 0, samples_checked = 0;
    ////////////////////////////////////////////////////////////////
    ewsp_window_addr dut_u (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .core_req_in, .core_write_in, .core_indirect_in,
        .core_repeat_in, .core_dword_in, .core_addr_in, .core_ready_out, .mem_valid_out,
        .mem_write_out, .mem_external_out, .mem_program_view_out, .mem_addr_out,
        .addr_trap_out, .irq_out);
    ewsp_mem_model mem_u (.ref_clk_in, .rst_n_in, .mem_valid_in(mem_valid_out),
        .mem_addr_in(mem_addr_out), .last_addr_out(last_addr), .beats_out(beats));
    // 40 MHz clock
    always #12.5 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////
    task close_out;
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk({8'h00, reg_rdata_out}, {8'h00, e});
    endtask
    // one core request, then count cycles until ready returns
    task acc(input logic w, input logic [15:0] a, input logic rp, input logic dw,
             input logic [23:0] ea, input logic [23:0] cyc, input logic tr);
        logic [23:0] n;
        @(posedge ref_clk_in);
        core_req_in <= 1'b1;
        core_write_in <= w;
        core_addr_in <= a;
        core_indirect_in <= a[15];
        core_repeat_in <= rp;
        core_dword_in <= dw;
        @(posedge ref_clk_in);
        core_req_in <= 1'b0;
        #1 chk({23'h0, addr_trap_out}, {23'h0, tr});
        n = 24'h1;
        if (!tr)
            chk(mem_addr_out, ea);
        while (core_ready_out !== 1'b1 && n < 24'h9)
        begin
            @(posedge ref_clk_in);
            #1 n = n + 24'h1;
        end
        if (!tr)
            chk(n, cyc);
    endtask
    task irq_is(input logic e);
        #1 chk({23'h0, irq_out}, {23'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog: whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        close_out;
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(4'h0, 16'h0001);
        rd(4'h1, 16'h0001);
        rd(4'h5, 16'h0001);
        rd(4'h2, 16'h0000);
        rd(4'h8, 16'h0000);
        wr(4'h0, 16'h0002);
        acc(1'b0, 16'h8800, 1'b0, 1'b0, 24'h010800, 24'h2, 1'b0);
        chk({23'h0, mem_program_view_out}, 24'h0);
        wr(4'h1, 16'h0003);
        acc(1'b1, 16'h8800, 1'b0, 1'b0, 24'h018800, 24'h1, 1'b0);
        acc(1'b0, 16'h8800, 1'b0, 1'b0, 24'h010800, 24'h2, 1'b0);
        acc(1'b0, 16'h1234, 1'b0, 1'b0, 24'h001234, 24'h1, 1'b0);
        acc(1'b0, 16'hfffe, 1'b0, 1'b0, 24'h017ffe, 24'h2, 1'b0);
        rd(4'h0, 16'h0002);
        wr(4'h0, 16'h0202);
        acc(1'b0, 16'h8800, 1'b0, 1'b0, 24'h010800, 24'h2, 1'b0);
        chk({23'h0, mem_program_view_out}, 24'h1);
        wr(4'h0, 16'h0002);
        acc(1'b0, 16'h8800, 1'b1, 1'b0, 24'h010800, 24'h3, 1'b0);
        acc(1'b0, 16'h8802, 1'b1, 1'b0, 24'h010802, 24'h3, 1'b0);
        acc(1'b0, 16'h8804, 1'b1, 1'b0, 24'h010804, 24'h1, 1'b0);
        // let the last read beat reach the model before taking the count
        @(posedge ref_clk_in);
        #1 b = {16'h0, beats};
        acc(1'b1, 16'h8000, 1'b0, 1'b1, 24'h018000, 24'h2, 1'b0);
        // model logs the second word one edge later
        @(posedge ref_clk_in);
        #1 chk(last_addr, 24'h018002);
        chk({16'h0, beats}, b + 24'h2);
        rd(4'h6, 16'h8000);
        rd(4'h7, 16'h0001);
        wr(4'h5, 16'h0000);
        acc(1'b0, 16'h8800, 1'b0, 1'b0, 24'h000800, 24'h2, 1'b0);
        wr(4'h5, 16'h0001);
        wr(4'h3, 16'h0007);
        wr(4'h4, 16'h0001);
        irq_is(1'b0);
        wr(4'h0, 16'h0000);
        acc(1'b0, 16'h8000, 1'b0, 1'b0, 24'h000000, 24'h2, 1'b1);
        irq_is(1'b1);
        wr(4'h4, 16'h0000);
        irq_is(1'b0);
        wr(4'h4, 16'h0001);
        irq_is(1'b1);
        wr(4'h3, 16'h0001);
        irq_is(1'b0);
        close_out;
    end
endmodule
`default_nettype wire
